// [t2c_pkg.sv]
// Package with the register map, field layouts and state types of the timer 2 control block.
package t2c_pkg;

  // ----------------------------------------------------------------
  // Bus widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_CONTROL = 12'h418;
  localparam logic [11:0] OFF_COUNT = 12'h41C;
  localparam logic [11:0] OFF_RELOAD = 12'h420;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h424;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h428;

  // ----------------------------------------------------------------
  // Reset values and counting constants
  // ----------------------------------------------------------------
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] RELOAD_RST = 16'h0000;
  localparam logic [1:0] IRQ_RST = 2'h0;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_WRAP = 16'h0000;
  localparam logic [7:0] PRESCALE_DIV = 8'h04;

  // ----------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------
  // Control register, bit 7 down to bit 0.
  typedef struct packed {
    logic timer2_overflow_flag;
    logic external_trigger_flag;
    logic uart0_rx_clock_select;
    logic uart0_tx_clock_select;
    logic external_trigger_enable;
    logic timer2_run;
    logic counter_timer_select;
    logic capture_reload_select;
  } t2c_ctrl_t;

  // Interrupt status and mask, bit 1 down to bit 0.
  typedef struct packed {
    logic ext;
    logic ovf;
  } t2c_irq_t;

  // ----------------------------------------------------------------
  // Module state
  // ----------------------------------------------------------------
  typedef struct packed {
    t2c_ctrl_t ctrl;
    logic [15:0] count;
    logic [15:0] reload;
    t2c_irq_t status;
    t2c_irq_t mask;
    logic trig_prev;
    logic event_prev;
    logic [15:0] rdata;
    logic rx_tick;
    logic tx_tick;
    logic irq;
  } t2c_state_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } t2c_pre_state_t;

endpackage

// [t2c_prescaler.sv]
// Divider that makes the one-cycle internal timing enable for timer 2.
`timescale 1ns/1ns
module t2c_prescaler #(
  parameter logic [7:0] DIV = t2c_pkg::PRESCALE_DIV
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  output logic tick
);

  t2c_pkg::t2c_pre_state_t r;
  t2c_pkg::t2c_pre_state_t s;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  // The divider runs free so that starting the timer never waits on a phase reset.
  always_comb begin
    s = r;
    if (r.cnt == DIV - 8'h01) begin
      s.cnt = 8'h00;
      s.tick = 1'b1;
    end else begin
      s.cnt = r.cnt + 8'h01;
      s.tick = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= s;
    end
  end

  assign tick = r.tick;

endmodule

// [t2c_timer2_control.sv]
// Timer 2 control register, 16-bit counter, capture and reload, baud clock selection and interrupt.
//
// Operation
// R1: Overflow flag never set during baud or clock-out use; only software clears it.
// R2: Enabled falling trigger edge causing capture or reload sets the external flag.
// R3: External flag raises the timer interrupt when enabled; only software clears it.
// R4: UART0 receive and transmit select timer 2 overflow rate as their baud clock.
// R5: Trigger pin edges cause capture or reload only while trigger enable is set.
// R6: Capture select with trigger enable copies the count on each falling trigger edge.
// R7: Reload select with trigger enable reloads on overflow and on falling trigger edges.
// R8: Run bit starts or holds the count; select picks internal clock or pin events.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ns
module t2c_timer2_control #(
  parameter logic [7:0] PRESCALE = t2c_pkg::PRESCALE_DIV
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [11:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic external_trigger_pin,
  input wire logic count_pin,
  input wire logic t1_overflow_tick,
  input wire logic uart1_rx_clock_select,
  input wire logic uart1_tx_clock_select,
  input wire logic clock_out_enable,
  output logic uart0_rx_baud_tick,
  output logic uart0_tx_baud_tick,
  output logic irq
);

  t2c_pkg::t2c_state_t r;
  t2c_pkg::t2c_state_t s;

  logic pre_tick;
  logic wr_ctrl;
  logic wr_count;
  logic wr_reload;
  logic wr_status;
  logic wr_mask;
  logic baud;
  logic ovf_block;
  logic trig_fall;
  logic event_fall;
  logic tick;
  logic ovf;
  logic ext_hit;
  logic rx_src;
  logic tx_src;

  // ----------------------------------------------------------------
  // Internal timing enable
  // ----------------------------------------------------------------
  t2c_prescaler #(
    .DIV(PRESCALE)
  ) u_prescaler (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .tick(pre_tick)
  );

  // ----------------------------------------------------------------
  // Decode and events
  // ----------------------------------------------------------------
  assign wr_ctrl = wr && (addr == t2c_pkg::OFF_CONTROL);
  assign wr_count = wr && (addr == t2c_pkg::OFF_COUNT);
  assign wr_reload = wr && (addr == t2c_pkg::OFF_RELOAD);
  assign wr_status = wr && (addr == t2c_pkg::OFF_IRQ_STATUS);
  assign wr_mask = wr && (addr == t2c_pkg::OFF_IRQ_MASK);

  // Any baud use of timer 2, on either UART, turns the counter into a pure rate source.
  assign baud = r.ctrl.uart0_rx_clock_select | r.ctrl.uart0_tx_clock_select
              | uart1_rx_clock_select | uart1_tx_clock_select;
  assign ovf_block = baud | clock_out_enable;

  // Pins are synchronous, so the edge detectors look at them directly.
  assign trig_fall = r.trig_prev & ~external_trigger_pin;
  assign event_fall = r.event_prev & ~count_pin;

  assign tick = r.ctrl.timer2_run && (r.ctrl.counter_timer_select ? event_fall : pre_tick); // R8
  assign ovf = tick && (r.count == t2c_pkg::COUNT_MAX);
  // The trigger pin does nothing while timer 2 only makes a baud rate.
  assign ext_hit = trig_fall && r.ctrl.external_trigger_enable && !baud; // R5

  assign rx_src = r.ctrl.uart0_rx_clock_select ? ovf : t1_overflow_tick; // R4
  assign tx_src = r.ctrl.uart0_tx_clock_select ? ovf : t1_overflow_tick; // R4

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s = r;
    s.rdata = 16'h0000;
    s.trig_prev = external_trigger_pin;
    s.event_prev = count_pin;
    s.rx_tick = rx_src; // R4
    s.tx_tick = tx_src; // R4

    // Software writes come first so that hardware events below win over them.
    if (wr_ctrl) begin
      s.ctrl = t2c_pkg::t2c_ctrl_t'(wdata[7:0]);
    end
    if (wr_count) begin
      s.count = wdata;
    end
    if (wr_reload) begin
      s.reload = wdata;
    end
    if (wr_status) begin
      s.status = t2c_pkg::t2c_irq_t'(r.status & ~wdata[1:0]);
    end
    if (wr_mask) begin
      s.mask = t2c_pkg::t2c_irq_t'(wdata[1:0]);
    end

    // Counting. Capture use wraps to zero; reload and baud use reload on overflow.
    if (tick) begin
      if (ovf) begin
        if (r.ctrl.capture_reload_select && !baud) begin
          s.count = t2c_pkg::COUNT_WRAP;
        end else begin
          s.count = r.reload; // R7
        end
      end else begin
        s.count = r.count + 16'h0001; // R8
      end
    end

    // Overflow flag. Only a write of zero clears it.
    if (ovf && !ovf_block) begin // R1
      s.ctrl.timer2_overflow_flag = 1'b1; // R1
      s.status.ovf = 1'b1;
    end

    // Trigger edge. A reload here overrides a same-cycle count step.
    if (ext_hit) begin // R5
      if (r.ctrl.capture_reload_select) begin
        s.reload = r.count; // R6
      end else begin
        s.count = r.reload; // R7
      end
      s.ctrl.external_trigger_flag = 1'b1; // R2
      s.status.ext = 1'b1; // R3
    end

    // Reads answer in the next cycle; unmapped addresses read zero.
    if (rd) begin
      if (addr == t2c_pkg::OFF_CONTROL) begin
        s.rdata = {8'h00, r.ctrl};
      end else if (addr == t2c_pkg::OFF_COUNT) begin
        s.rdata = r.count;
      end else if (addr == t2c_pkg::OFF_RELOAD) begin
        s.rdata = r.reload;
      end else if (addr == t2c_pkg::OFF_IRQ_STATUS) begin
        s.rdata = {14'h0000, r.status};
      end else if (addr == t2c_pkg::OFF_IRQ_MASK) begin
        s.rdata = {14'h0000, r.mask};
      end else begin
        s.rdata = 16'h0000;
      end
    end

    s.irq = |(s.status & s.mask); // R3
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // The pin history resets high, so a pin that is low at release is taken as a falling edge.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      r.ctrl <= t2c_pkg::t2c_ctrl_t'(t2c_pkg::CONTROL_RST);
      r.count <= t2c_pkg::COUNT_RST;
      r.reload <= t2c_pkg::RELOAD_RST;
      r.status <= t2c_pkg::t2c_irq_t'(t2c_pkg::IRQ_RST);
      r.mask <= t2c_pkg::t2c_irq_t'(t2c_pkg::IRQ_RST);
      r.trig_prev <= 1'b1;
      r.event_prev <= 1'b1;
      r.rdata <= 16'h0000;
      r.rx_tick <= 1'b0;
      r.tx_tick <= 1'b0;
      r.irq <= 1'b0;
    end else begin
      r <= s;
    end
  end

  assign rdata = r.rdata;
  assign uart0_rx_baud_tick = r.rx_tick;
  assign uart0_tx_baud_tick = r.tx_tick;
  assign irq = r.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_r1_ovf_blocked;
    @(posedge ref_clk) disable iff (!reset_n)
    $rose(r.ctrl.timer2_overflow_flag) && !$past(wr_ctrl) |-> !$past(ovf_block);
  endproperty
  a_r1_ovf_blocked: assert property (p_r1_ovf_blocked) // R1
    else $error("Overflow flag set during baud or clock-out use.");

  property p_r1_ovf_hold;
    @(posedge ref_clk) disable iff (!reset_n)
    r.ctrl.timer2_overflow_flag && !wr_ctrl |=> r.ctrl.timer2_overflow_flag;
  endproperty
  a_r1_ovf_hold: assert property (p_r1_ovf_hold) // R1
    else $error("Overflow flag cleared by hardware.");

  property p_r1_ovf_set;
    @(posedge ref_clk) disable iff (!reset_n)
    ovf && !ovf_block |=> r.ctrl.timer2_overflow_flag && r.status.ovf;
  endproperty
  a_r1_ovf_set: assert property (p_r1_ovf_set) // R1
    else $error("Overflow did not set its flag.");

  property p_r2_ext_set;
    @(posedge ref_clk) disable iff (!reset_n)
    ext_hit |=> r.ctrl.external_trigger_flag && r.status.ext;
  endproperty
  a_r2_ext_set: assert property (p_r2_ext_set) // R2
    else $error("Trigger edge did not set the external flag.");

  property p_r3_ext_hold;
    @(posedge ref_clk) disable iff (!reset_n)
    r.ctrl.external_trigger_flag && !wr_ctrl |=> r.ctrl.external_trigger_flag;
  endproperty
  a_r3_ext_hold: assert property (p_r3_ext_hold) // R3
    else $error("External flag cleared by hardware.");

  property p_r3_irq;
    @(posedge ref_clk) disable iff (!reset_n)
    ext_hit && r.mask.ext && !wr_mask |=> irq ##1 (irq || $past(wr_status) || $past(wr_mask));
  endproperty
  a_r3_irq: assert property (p_r3_irq) // R3
    else $error("Enabled external event did not raise the interrupt.");

  property p_r4_baud;
    @(posedge ref_clk) disable iff (!reset_n)
    r.ctrl.uart0_rx_clock_select && r.ctrl.uart0_tx_clock_select && ovf
      |=> uart0_rx_baud_tick && uart0_tx_baud_tick;
  endproperty
  a_r4_baud: assert property (p_r4_baud) // R4
    else $error("Timer 2 overflow missing on the UART0 baud ticks.");

  property p_r4_t1;
    @(posedge ref_clk) disable iff (!reset_n)
    !r.ctrl.uart0_rx_clock_select |=> uart0_rx_baud_tick == $past(t1_overflow_tick);
  endproperty
  a_r4_t1: assert property (p_r4_t1) // R4
    else $error("UART0 receive tick not taken from timer 1.");

  property p_r5_ignore;
    @(posedge ref_clk) disable iff (!reset_n)
    trig_fall && !r.ctrl.external_trigger_enable && !wr_ctrl && !wr_reload
      |=> !$rose(r.ctrl.external_trigger_flag) && $stable(r.reload);
  endproperty
  a_r5_ignore: assert property (p_r5_ignore) // R5
    else $error("Trigger edge acted while the trigger enable was clear.");

  property p_r6_capture;
    @(posedge ref_clk) disable iff (!reset_n)
    ext_hit && r.ctrl.capture_reload_select |=> r.reload == $past(r.count);
  endproperty
  a_r6_capture: assert property (p_r6_capture) // R6
    else $error("Count not captured on the trigger edge.");

  property p_r7_ext_reload;
    @(posedge ref_clk) disable iff (!reset_n)
    ext_hit && !r.ctrl.capture_reload_select |=> r.count == $past(r.reload);
  endproperty
  a_r7_ext_reload: assert property (p_r7_ext_reload) // R7
    else $error("Counter not reloaded on the trigger edge.");

  property p_r7_ovf_reload;
    @(posedge ref_clk) disable iff (!reset_n)
    ovf && !r.ctrl.capture_reload_select && !ext_hit |=> r.count == $past(r.reload);
  endproperty
  a_r7_ovf_reload: assert property (p_r7_ovf_reload) // R7
    else $error("Counter not reloaded on overflow.");

  property p_r8_stop;
    @(posedge ref_clk) disable iff (!reset_n)
    !r.ctrl.timer2_run && !wr_count && !ext_hit |=> $stable(r.count);
  endproperty
  a_r8_stop: assert property (p_r8_stop) // R8
    else $error("Count moved while the timer was stopped.");

  property p_r8_event;
    @(posedge ref_clk) disable iff (!reset_n)
    r.ctrl.timer2_run && r.ctrl.counter_timer_select && event_fall && !ovf && !wr_count && !ext_hit
      |=> r.count == $past(r.count) + 16'h0001;
  endproperty
  a_r8_event: assert property (p_r8_event) // R8
    else $error("Event edge did not advance the count.");

  property p_r2_ext_cause;
    @(posedge ref_clk) disable iff (!reset_n)
    $rose(r.ctrl.external_trigger_flag) && !$past(wr_ctrl)
      |-> $past(trig_fall) && $past(r.ctrl.external_trigger_enable);
  endproperty
  a_r2_ext_cause: assert property (p_r2_ext_cause) // R2
    else $error("External flag set without an enabled trigger edge.");

  property p_r1_status_blocked;
    @(posedge ref_clk) disable iff (!reset_n)
    ovf_block |=> !$rose(r.status.ovf);
  endproperty
  a_r1_status_blocked: assert property (p_r1_status_blocked) // R1
    else $error("Overflow status set during baud or clock-out use.");

  property p_r4_tx_t1;
    @(posedge ref_clk) disable iff (!reset_n)
    !r.ctrl.uart0_tx_clock_select |=> uart0_tx_baud_tick == $past(t1_overflow_tick);
  endproperty
  a_r4_tx_t1: assert property (p_r4_tx_t1) // R4
    else $error("UART0 transmit tick not taken from timer 1.");

  property p_r4_rx_ovf;
    @(posedge ref_clk) disable iff (!reset_n)
    r.ctrl.uart0_rx_clock_select |=> uart0_rx_baud_tick == $past(ovf);
  endproperty
  a_r4_rx_ovf: assert property (p_r4_rx_ovf) // R4
    else $error("UART0 receive tick does not follow the timer 2 overflow.");

  property p_r7_capture_wrap;
    @(posedge ref_clk) disable iff (!reset_n)
    ovf && r.ctrl.capture_reload_select && !baud && !ext_hit |=> r.count == t2c_pkg::COUNT_WRAP;
  endproperty
  a_r7_capture_wrap: assert property (p_r7_capture_wrap) // R7
    else $error("Capture mode overflow reloaded instead of wrapping.");

  property p_r8_timer;
    @(posedge ref_clk) disable iff (!reset_n)
    r.ctrl.timer2_run && !r.ctrl.counter_timer_select && pre_tick && !ovf && !wr_count && !ext_hit
      |=> r.count == $past(r.count) + 16'h0001;
  endproperty
  a_r8_timer: assert property (p_r8_timer) // R8
    else $error("Internal timing enable did not advance the count.");

  property p_r8_event_idle;
    @(posedge ref_clk) disable iff (!reset_n)
    r.ctrl.timer2_run && r.ctrl.counter_timer_select && !event_fall && !wr_count && !ext_hit
      |=> $stable(r.count);
  endproperty
  a_r8_event_idle: assert property (p_r8_event_idle) // R8
    else $error("Count moved in event mode without an event edge.");

endmodule

// [t2c_far_side.sv]
// Far-side model: trigger pin, event count pin and the other timer's overflow tick.
`timescale 1ns/1ns
module t2c_far_side (
  input wire logic ref_clk,
  output logic external_trigger_pin,
  output logic count_pin,
  output logic t1_overflow_tick
);
  // Pins idle high, so only a deliberate pulse makes a falling edge.
  initial begin
    external_trigger_pin = 1'b1;
    count_pin = 1'b1;
    t1_overflow_tick = 1'b0;
  end
  // Each pin low level is held two cycles so the edge detector sees it on a clock edge; the timer 1 tick is high for one cycle.
  task automatic fall_trigger();
    @(posedge ref_clk);
    external_trigger_pin <= 1'b0;
    repeat (2) @(posedge ref_clk);
    external_trigger_pin <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic pulse_count(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      count_pin <= 1'b0;
      repeat (2) @(posedge ref_clk);
      count_pin <= 1'b1;
      @(posedge ref_clk);
    end
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic tick_t1();
    @(posedge ref_clk);
    t1_overflow_tick <= 1'b1;
    @(posedge ref_clk);
    t1_overflow_tick <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
endmodule

// [tb.sv]
// Self-checking testbench for the timer 2 control block.
`timescale 1ns/1ns
`define CHK(what, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("ERROR %s expected %h seen %h", what, exp, got); \
    end \
  end
module tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [11:0] a;
    logic [15:0] d;
    logic [15:0] e;
  } t2c_row_t;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic ext_pin, cnt_pin, t1_tick;
  logic u1_rx = 1'b0;
  logic u1_tx = 1'b0;
  logic clk_oe = 1'b0;
  logic rx_tick, tx_tick, irq;
  int num_errors = 0;
  int total_checks = 0;
  int rx_cnt = 0;
  int tx_cnt = 0;
  int cycles = 0;
  t2c_row_t rows [6];
  always #50 ref_clk = ~ref_clk;
  t2c_timer2_control #(.PRESCALE(8'h02)) i_t2c_timer2_control (
    .ref_clk(ref_clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .external_trigger_pin(ext_pin), .count_pin(cnt_pin), .t1_overflow_tick(t1_tick),
    .uart1_rx_clock_select(u1_rx), .uart1_tx_clock_select(u1_tx), .clock_out_enable(clk_oe),
    .uart0_rx_baud_tick(rx_tick), .uart0_tx_baud_tick(tx_tick), .irq(irq));
  t2c_far_side i_t2c_far_side (
    .ref_clk(ref_clk), .external_trigger_pin(ext_pin), .count_pin(cnt_pin), .t1_overflow_tick(t1_tick));
  // Ticks are one cycle wide, so they are counted rather than caught in passing.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (rx_tick === 1'b1) rx_cnt <= rx_cnt + 1;
    if (tx_tick === 1'b1) tx_cnt <= tx_cnt + 1;
    if (cycles == 20000) begin
      num_errors++;
      summarize();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic bus_wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe; sampled just past that edge.
  task automatic chk_reg(input string what, input logic [11:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    `CHK(what, e, rdata);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    rows[0] = '{t2c_pkg::OFF_CONTROL, 16'hFF0B, 16'h000B};
    rows[1] = '{t2c_pkg::OFF_COUNT, 16'h1234, 16'h1234};
    rows[2] = '{t2c_pkg::OFF_RELOAD, 16'hBEEF, 16'hBEEF};
    rows[3] = '{t2c_pkg::OFF_IRQ_MASK, 16'h0003, 16'h0003};
    rows[4] = '{t2c_pkg::OFF_IRQ_STATUS, 16'h0003, 16'h0000};
    rows[5] = '{12'h42C, 16'h5555, 16'h0000};
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 6; i++) chk_reg("reset value", rows[i].a, 16'h0000);
    i_t2c_far_side.tick_t1();
    `CHK("rx tick from timer 1", 1, rx_cnt);
    `CHK("tx tick from timer 1", 1, tx_cnt);
    for (int i = 0; i < 6; i++) begin
      bus_wr(rows[i].a, rows[i].d);
      chk_reg("readback", rows[i].a, rows[i].e);
    end
    i_t2c_far_side.fall_trigger();
    chk_reg("captured count", t2c_pkg::OFF_RELOAD, 16'h1234);
    chk_reg("external flag", t2c_pkg::OFF_CONTROL, 16'h004B);
    chk_reg("ext status", t2c_pkg::OFF_IRQ_STATUS, 16'h0002);
    `CHK("irq on ext", 1'b1, irq);
    chk_reg("flag held", t2c_pkg::OFF_CONTROL, 16'h004B);
    bus_wr(t2c_pkg::OFF_CONTROL, 16'h000B);
    bus_wr(t2c_pkg::OFF_IRQ_STATUS, 16'h0002);
    chk_reg("flag cleared", t2c_pkg::OFF_CONTROL, 16'h000B);
    `CHK("irq cleared", 1'b0, irq);
    bus_wr(t2c_pkg::OFF_CONTROL, 16'h0001);
    bus_wr(t2c_pkg::OFF_COUNT, 16'h5678);
    i_t2c_far_side.fall_trigger();
    chk_reg("no capture", t2c_pkg::OFF_RELOAD, 16'h1234);
    chk_reg("no flag", t2c_pkg::OFF_CONTROL, 16'h0001);
    bus_wr(t2c_pkg::OFF_CONTROL, 16'h000A);
    bus_wr(t2c_pkg::OFF_RELOAD, 16'hBEEF);
    i_t2c_far_side.fall_trigger();
    chk_reg("trigger reload", t2c_pkg::OFF_COUNT, 16'hBEEF);
    chk_reg("reload flag", t2c_pkg::OFF_CONTROL, 16'h004A);
    bus_wr(t2c_pkg::OFF_IRQ_STATUS, 16'h0002);
    bus_wr(t2c_pkg::OFF_CONTROL, 16'h0006);
    bus_wr(t2c_pkg::OFF_COUNT, 16'h0005);
    i_t2c_far_side.pulse_count(3);
    chk_reg("event count", t2c_pkg::OFF_COUNT, 16'h0008);
    bus_wr(t2c_pkg::OFF_CONTROL, 16'h0002);
    i_t2c_far_side.pulse_count(2);
    chk_reg("stopped count", t2c_pkg::OFF_COUNT, 16'h0008);
    bus_wr(t2c_pkg::OFF_RELOAD, 16'h0100);
    bus_wr(t2c_pkg::OFF_COUNT, 16'hFFFF);
    bus_wr(t2c_pkg::OFF_CONTROL, 16'h0006);
    i_t2c_far_side.pulse_count(1);
    chk_reg("overflow reload", t2c_pkg::OFF_COUNT, 16'h0100);
    chk_reg("overflow flag", t2c_pkg::OFF_CONTROL, 16'h0086);
    chk_reg("ovf status", t2c_pkg::OFF_IRQ_STATUS, 16'h0001);
    `CHK("irq on ovf", 1'b1, irq);
    bus_wr(t2c_pkg::OFF_CONTROL, 16'h0002);
    bus_wr(t2c_pkg::OFF_IRQ_STATUS, 16'h0001);
    clk_oe <= 1'b1;
    bus_wr(t2c_pkg::OFF_COUNT, 16'hFFFF);
    bus_wr(t2c_pkg::OFF_CONTROL, 16'h0006);
    i_t2c_far_side.pulse_count(1);
    chk_reg("flag blocked", t2c_pkg::OFF_CONTROL, 16'h0006);
    chk_reg("status blocked", t2c_pkg::OFF_IRQ_STATUS, 16'h0000);
    clk_oe <= 1'b0;
    bus_wr(t2c_pkg::OFF_CONTROL, 16'h0002);
    bus_wr(t2c_pkg::OFF_COUNT, 16'hFFFF);
    bus_wr(t2c_pkg::OFF_CONTROL, 16'h0036);
    i_t2c_far_side.tick_t1();
    `CHK("rx ignores timer 1", 1, rx_cnt);
    `CHK("tx ignores timer 1", 1, tx_cnt);
    i_t2c_far_side.pulse_count(1);
    `CHK("rx from timer 2", 2, rx_cnt);
    `CHK("tx from timer 2", 2, tx_cnt);
    chk_reg("baud no flag", t2c_pkg::OFF_CONTROL, 16'h0036);
    chk_reg("baud reload", t2c_pkg::OFF_COUNT, 16'h0100);
    u1_rx <= 1'b1;
    u1_tx <= 1'b1;
    bus_wr(t2c_pkg::OFF_CONTROL, 16'h0002);
    bus_wr(t2c_pkg::OFF_COUNT, 16'hFFFF);
    bus_wr(t2c_pkg::OFF_CONTROL, 16'h0007);
    i_t2c_far_side.pulse_count(1);
    chk_reg("uart1 blocks flag", t2c_pkg::OFF_CONTROL, 16'h0007);
    chk_reg("uart1 baud reload", t2c_pkg::OFF_COUNT, 16'h0100);
    u1_rx <= 1'b0;
    u1_tx <= 1'b0;
    bus_wr(t2c_pkg::OFF_COUNT, 16'hFFFF);
    i_t2c_far_side.pulse_count(1);
    chk_reg("capture wrap", t2c_pkg::OFF_COUNT, 16'h0000);
    chk_reg("capture ovf flag", t2c_pkg::OFF_CONTROL, 16'h0087);
    bus_wr(t2c_pkg::OFF_COUNT, 16'h0010);
    bus_wr(t2c_pkg::OFF_CONTROL, 16'h0004);
    repeat (8) @(posedge ref_clk);
    bus_wr(t2c_pkg::OFF_CONTROL, 16'h0000);
    chk_reg("timer count", t2c_pkg::OFF_COUNT, 16'h0015);
    summarize();
  end
endmodule
